// ---- design/mem_bus_arbiter.sv ----
// Fixed-priority arbiter for the internal memory bus
`timescale 1ns/1ns
`default_nettype none
module mem_bus_arbiter
  import sound_cache_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic [3:0] i_req,   // 0 fill, 1 host, 2 uart, 3 serial
  output logic      [3:0] o_gnt    // One-hot grant, one cycle per access
);
  logic [3:0] gnt_d;
  logic [3:0] gnt_q;
  // Lowest-numbered set request wins; one grant per memory cycle
  assign gnt_d = i_req[0] ? 4'h1 :
                 i_req[1] ? 4'h2 :
                 i_req[2] ? 4'h4 :
                 i_req[3] ? 4'h8 : 4'h0;
  // Grant is held during the single cycle the longword access takes
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      gnt_q <= 4'h0;
    end else begin
      gnt_q <= (gnt_q != 4'h0) ? 4'h0 : gnt_d;
    end
  end
  assign o_gnt = gnt_q;
endmodule
`default_nettype wire

// ---- design/sound_cache_bus_master.sv ----
// Three-channel cache fill engine with 256-byte sound cache
//
// What this block does
// - Memory bus priority: fill, host, uart, serial
// - Cache is four 64-byte blocks, 16-byte pages
// - Cache accessed only as whole longwords
// - Blocks 0-2 are playback one, two, record
// - First two pages lower half, last upper
// - Block 3 pages C, D hold frame info
// - Pages E, F hold UART FIFO, bits 8:0
// - UART keeps eight-entry FIFO in cache
// - Sixteen register longwords; byte-wide writes zero other lanes
// - Every bus-master transfer is eight longwords
// - Read request triggers eight-longword burst read
// - Fill aligns data and writes correct buffer
// - Finish current transfer before next request
// - Record: load buffer, then request write
// - Writes always send eight longwords
// - Channel interrupts summarised; fill irq masked centrally
// - Serial side flags fill or flush need
// - Host window access arbitrates, then acknowledges
`timescale 1ns/1ns
`default_nettype none
`include "sound_cache_consts.svh"
module sound_cache_bus_master
  import sound_cache_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Serial interface demands: bit per channel, and which half
  input  wire logic [2:0]  i_xfer_need,   // 0 pb1, 1 pb2, 2 rec
  input  wire logic [2:0]  i_xfer_half,   // 1 selects upper half
  input  wire logic [31:0] i_sys_addr_pb1,
  input  wire logic [31:0] i_sys_addr_pb2,
  input  wire logic [31:0] i_sys_addr_rec,
  input  wire logic [3:0]  i_rec_valid,   // Valid longwords 1..8
  output logic      [2:0]  o_xfer_done,   // Pulse when channel served
  // Host bus master unit
  output burst_cmd_t       o_burst_cmd,
  input  wire logic        i_burst_ack,   // Command accepted
  input  wire logic        i_rd_valid,    // Read beat available
  input  wire logic [31:0] i_rd_data,
  input  wire logic        i_wr_ready,    // Write beat consumed
  output logic      [31:0] o_wr_data,
  input  wire logic [1:0]  i_byte_shift,  // Byte alignment of reads
  // Host register window
  input  wire logic        i_host_req,
  input  wire logic        i_host_we,
  input  wire logic [3:0]  i_host_be,
  input  wire logic [3:0]  i_host_reg,    // Longword index of 16
  input  wire logic [31:0] i_host_wdata,
  output logic             o_host_ack,
  output logic      [31:0] o_host_rdata,
  // UART FIFO access
  input  wire logic        i_uart_req,
  input  wire logic        i_uart_we,
  input  wire logic [2:0]  i_uart_slot,
  input  wire logic [8:0]  i_uart_wdata,
  output logic             o_uart_ack,
  output logic      [8:0]  o_uart_rdata,
  // Serial sample access
  input  wire logic        i_ser_req,
  input  wire logic        i_ser_we,
  input  wire logic [5:0]  i_ser_addr,
  input  wire logic [31:0] i_ser_wdata,
  output logic             o_ser_ack,
  output logic      [31:0] o_ser_rdata,
  // Interrupts
  input  wire logic [1:0]  i_chan_irq,    // Pre-masked channel irqs
  input  wire logic        i_fill_irq_en, // Central mask of fill irq
  output logic             o_irq
);
  // Cache memory: 64 longwords, page in upper address bits
  logic [31:0] cache_mem [0:63];
  // Page register used by the host window
  logic [3:0]  page_q;
  // Fill controller state
  fill_state_t st_q;
  fill_state_t st_d;
  logic [1:0]  chan_q;          // Channel being served
  logic        half_q;          // Half buffer being served
  logic [2:0]  beat_q;          // Beat counter in burst
  logic [31:0] bbuf [0:7];      // Intermediate bus buffer
  logic [31:0] prev_q;          // Previous beat for alignment
  logic        fill_irq_q;      // Sticky fill completion event
  // Arbiter wiring
  logic [3:0]  req;
  logic [3:0]  gnt;
  mem_req_t    fill_r;
  mem_req_t    host_r;
  mem_req_t    uart_r;
  mem_req_t    ser_r;
  mem_req_t    sel_r;
  logic        host_is_page;    // Host index 3 is the page register
  logic        host_is_win;     // Indices 12..15 are the window
  logic        host_busy_q;     // Host access granted, ack next
  logic        fill_mem_go;
  logic [31:0] aligned;
  logic [3:0]  base_page;
  logic [5:0]  fill_word;
  logic [31:0] host_merge;
  logic [1:0]  next_chan;
  logic        any_need;

  // Register window decode; only the cache window uses the bus, page reg answers directly
  assign host_is_page = (i_host_reg == 4'h3);
  assign host_is_win  = (i_host_reg[3:2] == 2'h3);
  // Byte lanes not enabled are written as zero; reads always full
  assign host_merge = { i_host_be[3] ? i_host_wdata[31:24] : 8'h00,
                        i_host_be[2] ? i_host_wdata[23:16] : 8'h00,
                        i_host_be[1] ? i_host_wdata[15:8]  : 8'h00,
                        i_host_be[0] ? i_host_wdata[7:0]   : 8'h00 };

  // Channel base page and addressed cache word
  assign base_page = (chan_q == `CH_PB1) ? `PAGE_PB1_BASE :
                     (chan_q == `CH_PB2) ? `PAGE_PB2_BASE :
                     `PAGE_REC_BASE;
  // Half selects pages 0-1 or 2-3 of the block; beats ascend
  assign fill_word = {base_page[3:2], half_q, beat_q};

  // Byte alignment: shift pair of beats by the requested bytes
  assign aligned = (i_byte_shift == 2'h0) ? i_rd_data :
                   (i_byte_shift == 2'h1) ? {i_rd_data[7:0], prev_q[31:8]} :
                   (i_byte_shift == 2'h2) ? {i_rd_data[15:0], prev_q[31:16]} :
                   {i_rd_data[23:0], prev_q[31:24]};

  // Fixed priority among pending channels: record, pb1, pb2
  assign any_need  = |i_xfer_need;
  assign next_chan = i_xfer_need[2] ? `CH_REC :
                     i_xfer_need[0] ? `CH_PB1 : `CH_PB2;

  // Fill controller wants the memory during moves and loads
  assign fill_mem_go = ((st_q == ST_RDMOV) && i_rd_valid) ||
                       (st_q == ST_WRLD);
  assign fill_r.req  = fill_mem_go;
  assign fill_r.we   = (st_q == ST_RDMOV);
  assign fill_r.addr = fill_word;
  assign fill_r.wdata = aligned;

  // Host requests only for the cache window, after page set-up
  assign host_r.req  = i_host_req && host_is_win && !host_busy_q;
  assign host_r.we   = i_host_we;
  assign host_r.addr = {page_q, i_host_reg[1:0]};
  assign host_r.wdata = host_merge;

  // UART FIFO eight slots map to pages E and F
  assign uart_r.req  = i_uart_req;
  assign uart_r.we   = i_uart_we;
  assign uart_r.addr = {(i_uart_slot[2] ? `PAGE_UART_HI : `PAGE_UART_LO),
                        i_uart_slot[1:0]};
  assign uart_r.wdata = {23'h000000, i_uart_wdata};

  // Serial interface reaches sample and frame pages directly
  assign ser_r.req   = i_ser_req;
  assign ser_r.we    = i_ser_we;
  assign ser_r.addr  = i_ser_addr;
  assign ser_r.wdata = i_ser_wdata;

  assign req = {ser_r.req, uart_r.req, host_r.req, fill_r.req};

  // Fill path is highest and never waits when the bus is free
  mem_bus_arbiter u_arb (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_req  (req),
    .o_gnt  (gnt)
  );

  // Granted requester's longword drives the memory
  assign sel_r = gnt[0] ? fill_r : gnt[1] ? host_r :
                 gnt[2] ? uart_r : ser_r;

  // Cache array, whole longwords only
  always_ff @(posedge i_clk) begin
    if (|gnt && sel_r.we) begin
      cache_mem[sel_r.addr] <= sel_r.wdata;
    end
  end

  // Fill state machine next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:  if (any_need) st_d = (next_chan == `CH_REC) ?
                                     ST_WRLD : ST_RDREQ;
      ST_RDREQ: if (i_burst_ack) st_d = ST_RDMOV;
      ST_RDMOV: if (gnt[0] && beat_q == `BURST_LAST) st_d = ST_IDLE;
      ST_WRLD:  if (gnt[0] && beat_q == `BURST_LAST) st_d = ST_WRREQ;
      ST_WRREQ: if (i_burst_ack) st_d = ST_WRSND;
      ST_WRSND: if (i_wr_ready && beat_q == `BURST_LAST) st_d = ST_IDLE;
      default:  st_d = ST_IDLE;
    endcase
  end

  // State, channel, beat counting and buffers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_q   <= ST_IDLE;
      chan_q <= `CH_PB1;
      half_q <= 1'b0;
      beat_q <= 3'h0;
      prev_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      if (st_q == ST_IDLE && any_need) begin
        chan_q <= next_chan;
        half_q <= i_xfer_half[next_chan];
        beat_q <= 3'h0;
      end
      // Keep the beat only once it is moved, so alignment pairs
      // each word with the one before it, not with itself
      if (st_q == ST_RDMOV && i_rd_valid && gnt[0]) begin
        prev_q <= i_rd_data;
      end
      // Beats counted only as each longword is really moved
      if ((fill_mem_go && gnt[0]) || (st_q == ST_WRSND && i_wr_ready)) begin
        beat_q <= beat_q + 3'h1;
      end
    end
  end

  // Bus buffer loads record words; beyond valid count they are zero
  always_ff @(posedge i_clk) begin
    if (st_q == ST_WRLD && gnt[0]) begin
      bbuf[beat_q] <= ({1'b0, beat_q} < i_rec_valid) ? rdata_q_next()
                                                     : 32'h00000000;
    end
  end

  // Read data of the granted fill access, same cycle
  function automatic logic [31:0] rdata_q_next();
    rdata_q_next = cache_mem[fill_word];
  endfunction

  // Burst command and write data toward the bus master unit
  assign o_burst_cmd.valid = (st_q == ST_RDREQ) || (st_q == ST_WRREQ);
  assign o_burst_cmd.write = (st_q == ST_WRREQ);
  assign o_burst_cmd.addr  = (chan_q == `CH_PB1) ? i_sys_addr_pb1 :
                             (chan_q == `CH_PB2) ? i_sys_addr_pb2 :
                             i_sys_addr_rec;
  // All eight beats go out regardless of valid count
  assign o_wr_data = (st_q == ST_WRSND) ? bbuf[beat_q] : 32'h00000000;

  // Completion pulses and sticky fill interrupt
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_xfer_done <= 3'h0;
      fill_irq_q  <= 1'b0;
    end else begin
      o_xfer_done <= 3'h0;
      if (st_q != ST_IDLE && st_d == ST_IDLE) begin
        o_xfer_done[chan_q] <= 1'b1;
        fill_irq_q <= 1'b1;
      end else if (!i_fill_irq_en) begin
        fill_irq_q <= 1'b0;
      end
    end
  end
  // Only the fill event is masked here; others arrive pre-masked
  assign o_irq = (|i_chan_irq) | (fill_irq_q & i_fill_irq_en);

  // Page register and host acknowledge
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      page_q       <= `PAGE_PB1_BASE;
      host_busy_q  <= 1'b0;
      o_host_ack   <= 1'b0;
      o_host_rdata <= 32'h00000000;
    end else begin
      o_host_ack  <= 1'b0;
      host_busy_q <= gnt[1];
      if (i_host_req && host_is_page && !o_host_ack) begin
        if (i_host_we && i_host_be[0]) page_q <= i_host_wdata[3:0];
        o_host_ack   <= 1'b1;
        o_host_rdata <= {28'h0000000, page_q};
      end else if (i_host_req && !host_is_win && !host_is_page
                   && !o_host_ack) begin
        o_host_ack   <= 1'b1;
        o_host_rdata <= 32'h00000000;
      end
      if (gnt[1]) begin
        o_host_ack   <= 1'b1;
        o_host_rdata <= cache_mem[host_r.addr];
      end
    end
  end

  // UART and serial answers one cycle after grant
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_uart_ack   <= 1'b0;
      o_ser_ack    <= 1'b0;
      o_uart_rdata <= 9'h000;
      o_ser_rdata  <= 32'h00000000;
    end else begin
      o_uart_ack <= gnt[2];
      o_ser_ack  <= gnt[3];
      if (gnt[2]) o_uart_rdata <= cache_mem[uart_r.addr][8:0];
      if (gnt[3]) o_ser_rdata  <= cache_mem[ser_r.addr];
    end
  end
endmodule
`default_nettype wire

// ---- design/sound_cache_consts.svh ----
// Constants for the sound cache bus master engine
`ifndef SOUND_CACHE_CONSTS_SVH
`define SOUND_CACHE_CONSTS_SVH
`define BURST_LEN        4'h8
`define BURST_LAST       3'h7
`define PAGE_PB1_BASE    4'h0
`define PAGE_PB2_BASE    4'h4
`define PAGE_REC_BASE    4'h8
`define PAGE_FRAME_PB    4'hC
`define PAGE_FRAME_REC   4'hD
`define PAGE_UART_LO     4'hE
`define PAGE_UART_HI     4'hF
`define UART_DATA_MASK   32'h000001FF
`define CH_PB1           2'h0
`define CH_PB2           2'h1
`define CH_REC           2'h2
`define REG_WORDS        5'h10
`endif

// ---- design/sound_cache_pkg.sv ----
// Types shared by the sound cache engine files
package sound_cache_pkg;
  // Longword address into the 64-word cache: page and word in page
  typedef struct packed {
    logic [3:0] page;
    logic [1:0] word;
  } cache_addr_t;
  // One requester's access to the internal memory bus
  typedef struct packed {
    logic        req;
    logic        we;
    cache_addr_t addr;
    logic [31:0] wdata;
  } mem_req_t;
  // Burst command toward the host bus master unit
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } burst_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RDREQ = 3'b001,
    ST_RDMOV = 3'b010,
    ST_WRLD  = 3'b011,
    ST_WRREQ = 3'b100,
    ST_WRSND = 3'b101
  } fill_state_t;
endpackage

// ---- verification/host_bus_model.sv ----
// Host bus master unit with system memory behind it
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
  import sound_cache_pkg::*;
(
  input  wire logic        i_clk,
  input  wire burst_cmd_t  i_cmd,
  input  wire logic [31:0] i_wr_data,
  input  wire logic [1:0]  i_stall,    // Extra cycles before accept
  output logic             o_ack,
  output logic             o_rd_valid,
  output logic      [31:0] o_rd_data,
  output logic             o_wr_ready
);
  logic [31:0] wr_seen [8];  // Longwords landed in system memory
  logic [31:0] a;            // Burst start address
  logic        w;            // Burst direction
  initial begin
    o_ack = 1'b0;
    o_rd_valid = 1'b0;
    o_rd_data = 32'h0;
    o_wr_ready = 1'b0;
    forever begin
      @(posedge i_clk iff i_cmd.valid);
      repeat (i_stall) @(posedge i_clk);
      a = i_cmd.addr;
      w = i_cmd.write;
      #1 o_ack = 1'b1;
      @(posedge i_clk);
      #1 o_ack = 1'b0;
      // Always eight whole longwords, whatever was valid
      for (int k = 0; k < 8; k++) begin
        o_wr_ready = w;
        o_rd_valid = !w;
        o_rd_data = w ? ~o_rd_data : a + k;
        // Write data is settled here, well before the consuming edge
        if (w) wr_seen[k] = i_wr_data;
        // A read beat stands two cycles so it spans one grant
        repeat (w ? 1 : 2) @(posedge i_clk);
        #1 o_wr_ready = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_data = ~o_rd_data;  // Released data must not linger
        @(posedge i_clk);
        #1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/sound_cache_bus_master_properties.sv ----
// Port-level assertions for the sound cache bus master engine
`timescale 1ns/1ns
`default_nettype none
module sound_cache_bus_master_properties
  import sound_cache_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic [2:0]  i_xfer_need,
  input wire logic [2:0]  o_xfer_done,
  input wire burst_cmd_t  o_burst_cmd,
  input wire logic        i_burst_ack,
  input wire logic        i_wr_ready,
  input wire logic [31:0] i_sys_addr_rec,
  input wire logic        i_host_req,
  input wire logic        o_host_ack,
  input wire logic        i_uart_req,
  input wire logic        o_uart_ack,
  input wire logic        i_ser_req,
  input wire logic        o_ser_ack,
  input wire logic [1:0]  i_chan_irq,
  input wire logic        o_irq
);
  logic [3:0] wr_cnt_q;  // Write beats since the last write command
  logic       busy_q;    // Set from command accept until done
  // Count beats so a short write burst shows up at done
  always_ff @(posedge i_clk) begin
    if (!i_nrst || (i_burst_ack && o_burst_cmd.write)) wr_cnt_q <= 4'h0;
    else if (i_wr_ready) wr_cnt_q <= wr_cnt_q + 4'h1;
  end
  // Track one burst in flight
  always_ff @(posedge i_clk) begin
    if (!i_nrst || |o_xfer_done) busy_q <= 1'b0;
    else if (i_burst_ack) busy_q <= 1'b1;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  a_host_over_uart: assert property (
    $rose(i_host_req) && $rose(i_uart_req) |-> (!o_uart_ack until o_host_ack))
    else $error("uart served ahead of host");
  a_uart_over_ser: assert property (
    $rose(i_uart_req) && $rose(i_ser_req) |-> (!o_ser_ack until o_uart_ack))
    else $error("serial served ahead of uart");
  a_host_ack_soon: assert property (
    $rose(i_host_req) |-> ##[1:40] o_host_ack)
    else $error("host access not acknowledged");
  a_uart_ack_soon: assert property (
    $rose(i_uart_req) |-> ##[1:60] o_uart_ack)
    else $error("uart access not acknowledged");
  a_ack_single: assert property (
    o_host_ack |=> !o_host_ack)
    else $error("host ack longer than one cycle");
  a_cmd_held: assert property (
    o_burst_cmd.valid && !i_burst_ack |=> o_burst_cmd.valid && $stable(o_burst_cmd))
    else $error("burst command dropped before accept");
  a_rec_addr: assert property (
    o_burst_cmd.valid && o_burst_cmd.write |-> o_burst_cmd.addr == i_sys_addr_rec)
    else $error("write burst address wrong");
  a_write_eight: assert property (
    o_xfer_done[2] |-> wr_cnt_q == 4'h8)
    else $error("write burst not eight beats");
  a_one_burst: assert property (
    $rose(o_burst_cmd.valid) |-> !busy_q)
    else $error("new burst before previous finished");
  a_done_cause: assert property (
    |o_xfer_done |-> (o_xfer_done & ~$past(i_xfer_need)) == 3'h0)
    else $error("done without a pending need");
  a_irq_chan: assert property (
    i_chan_irq != 2'h0 |-> o_irq)
    else $error("channel interrupt not summarised");
  c_write: cover property (o_xfer_done[2]);
  c_read: cover property (o_xfer_done[0]);
  c_contend: cover property ($rose(i_host_req) && $rose(i_uart_req));
endmodule
bind sound_cache_bus_master sound_cache_bus_master_properties u_props (
  .i_clk, .i_nrst, .i_xfer_need, .o_xfer_done, .o_burst_cmd, .i_burst_ack,
  .i_wr_ready, .i_sys_addr_rec, .i_host_req, .o_host_ack, .i_uart_req,
  .o_uart_ack, .i_ser_req, .o_ser_ack, .i_chan_irq, .o_irq);
`default_nettype wire

// ---- verification/sound_cache_bus_master_test.sv ----
// Self-checking bench for the sound cache bus master engine
`timescale 1ns/1ns
`default_nettype none
module sound_cache_bus_master_test;
  import sound_cache_pkg::*;
  logic        i_clk = 1'b0, i_nrst = 1'b0, o_irq, o_host_ack;
  logic [2:0]  i_xfer_need = 3'h0, i_xfer_half = 3'h0, o_xfer_done;
  logic [31:0] i_sys_addr_pb1 = 32'h0, i_sys_addr_pb2 = 32'h0, d;
  logic [31:0] i_sys_addr_rec = 32'h0, i_rd_data, o_wr_data, exp_q [8];
  logic [3:0]  i_rec_valid = 4'h8, i_host_be = 4'hF, i_host_reg = 4'h0;
  burst_cmd_t  o_burst_cmd;
  logic        i_burst_ack, i_rd_valid, i_wr_ready, i_fill_irq_en = 1'b0;
  logic [1:0]  stall = 2'h0, i_chan_irq = 2'h0, i_byte_shift = 2'h0;
  logic        i_host_req = 1'b0, i_host_we = 1'b0, o_uart_ack, o_ser_ack;
  logic [31:0] i_host_wdata = 32'h0, o_host_rdata, o_ser_rdata;
  logic        i_uart_req = 1'b0, i_uart_we = 1'b0, i_ser_we = 1'b0;
  logic [2:0]  i_uart_slot = 3'h0;
  logic [8:0]  i_uart_wdata = 9'h0, o_uart_rdata;
  logic        i_ser_req = 1'b0;
  logic [5:0]  i_ser_addr = 6'h0;
  logic [31:0] i_ser_wdata = 32'h0;
  logic [15:0] seed = 16'h002C;  // Fixed start keeps runs repeatable
  int          fails = 0, samples_checked = 0;
  always #25 i_clk = ~i_clk;
  sound_cache_bus_master dut (
    .i_clk, .i_nrst, .i_xfer_need, .i_xfer_half, .i_sys_addr_pb1,
    .i_sys_addr_pb2, .i_sys_addr_rec, .i_rec_valid, .o_xfer_done,
    .o_burst_cmd, .i_burst_ack, .i_rd_valid, .i_rd_data, .i_wr_ready,
    .o_wr_data, .i_byte_shift, .i_host_req, .i_host_we, .i_host_be,
    .i_host_reg, .i_host_wdata, .o_host_ack, .o_host_rdata, .i_uart_req,
    .i_uart_we, .i_uart_slot, .i_uart_wdata, .o_uart_ack, .o_uart_rdata,
    .i_ser_req, .i_ser_we, .i_ser_addr, .i_ser_wdata, .o_ser_ack,
    .o_ser_rdata, .i_chan_irq, .i_fill_irq_en, .o_irq);
  host_bus_model hbm (
    .i_clk, .i_cmd(o_burst_cmd), .i_wr_data(o_wr_data), .i_stall(stall),
    .o_ack(i_burst_ack), .o_rd_valid(i_rd_valid), .o_rd_data(i_rd_data),
    .o_wr_ready(i_wr_ready));
  // Linear feedback shift register source of random values
  function automatic logic [31:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, seed ^ 16'hA5C3};
  endfunction
  // Words past the valid count go out as zero
  function automatic logic [31:0] rec_exp(input int k, input logic [31:0] v);
    return (k < i_rec_valid) ? v : 32'h0;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Wait at falling edges for a pulse: 0 host, 1 uart, 2 serial, 3+ done
  task automatic wait_hi(input int s);
    int n;
    logic [5:0] v;
    for (n = 0; n < 400; n++) begin
      @(negedge i_clk);
      v = {o_xfer_done, o_ser_ack, o_uart_ack, o_host_ack};
      if (v[s] === 1'b1) break;
    end
    if (n == 400) fails++;
  endtask
  task automatic host(input logic we, input logic [3:0] r, input logic [31:0] wd);
    @(negedge i_clk);
    {i_host_req, i_host_we, i_host_reg, i_host_wdata} = {1'b1, we, r, wd};
    wait_hi(0);
    i_host_req = 1'b0;
  endtask
  task automatic uart(input logic we, input logic [2:0] s, input logic [8:0] wd);
    @(negedge i_clk);
    {i_uart_req, i_uart_we, i_uart_slot, i_uart_wdata} = {1'b1, we, s, wd};
    wait_hi(1);
    i_uart_req = 1'b0;
  endtask
  task automatic ser(input logic we, input logic [5:0] a, input logic [31:0] wd);
    @(negedge i_clk);
    {i_ser_req, i_ser_we, i_ser_addr, i_ser_wdata} = {1'b1, we, a, wd};
    wait_hi(2);
    i_ser_req = 1'b0;
  endtask
  // Page register first, then the window word
  task automatic win(input logic [3:0] pg, input logic [1:0] w,
                     input logic we, input logic [31:0] wd);
    host(1'b1, 4'h3, {28'h0, pg});
    host(we, {2'b11, w}, wd);
  endtask
  task automatic xfer(input int ch, input logic h);
    @(negedge i_clk);
    d = rnd();
    stall = d[1:0];
    i_xfer_half[ch] = h;
    i_xfer_need[ch] = 1'b1;
    wait_hi(3 + ch);
    i_xfer_need[ch] = 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    i_nrst = 1'b1;
    check({28'h0, o_xfer_done, o_irq}, 32'h0);
    for (int ch = 0; ch < 2; ch++) begin
      for (int h = 0; h < 2; h++) begin
        exp_q[0] = rnd();
        if (ch == 0) i_sys_addr_pb1 = exp_q[0];
        else i_sys_addr_pb2 = exp_q[0];
        xfer(ch, h[0]);
        for (int w = 0; w < 8; w++) begin
          win(4'(4 * ch + 2 * h + w / 4), 2'(w), 1'b0, 32'h0);
          check(o_host_rdata, exp_q[0] + w);
        end
      end
    end
    i_xfer_need = 3'h3;  // Two fills pending together
    wait_hi(3);
    i_xfer_need[0] = 1'b0;
    wait_hi(4);
    i_xfer_need = 3'h0;
    // Two-byte shift: each word joins this beat and the one before
    i_byte_shift = 2'h2;
    exp_q[0] = rnd();
    i_sys_addr_pb2 = exp_q[0];
    xfer(1, 1'b0);
    i_byte_shift = 2'h0;
    for (int w = 1; w < 8; w++) begin
      win(4'(4 + w / 4), 2'(w), 1'b0, 32'h0);
      d = exp_q[0] + w - 1;
      check(o_host_rdata, {16'(exp_q[0] + w), d[31:16]});
    end
    $display("playback test done");
    i_fill_irq_en = 1'b1;
    for (int h = 0; h < 2; h++) begin
      d = rnd();
      i_rec_valid = h ? 4'h8 : {1'b0, d[2:0]} + 4'h1;
      i_sys_addr_rec = rnd();
      for (int w = 0; w < 8; w++) begin
        exp_q[w] = rnd();
        win(4'(8 + 2 * h + w / 4), 2'(w), 1'b1, exp_q[w]);
      end
      xfer(2, h[0]);
      for (int k = 0; k < 8; k++) check(hbm.wr_seen[k], rec_exp(k, exp_q[k]));
      @(negedge i_clk);
      check({31'h0, o_irq}, 32'h1);
    end
    i_fill_irq_en = 1'b0;
    @(negedge i_clk);
    check({31'h0, o_irq}, 32'h0);
    i_chan_irq = 2'h2;
    @(negedge i_clk);
    check({31'h0, o_irq}, 32'h1);
    i_chan_irq = 2'h0;
    $display("record test done");
    for (int s = 0; s < 8; s++) begin
      d = rnd();
      fork
        uart(1'b1, 3'(s), d[8:0]);
        host(1'b0, 4'h5, 32'h0);
      join
      check(o_host_rdata, 32'h0);
      win(4'(14 + s / 4), 2'(s), 1'b0, 32'h0);
      check(o_host_rdata, {23'h0, d[8:0]});
    end
    win(4'hF, 2'h3, 1'b1, 32'hFFFFFFFF);
    fork
      uart(1'b0, 3'h7, 9'h0);
      ser(1'b1, 6'h01, d);
    join
    check({23'h0, o_uart_rdata}, 32'h1FF);
    ser(1'b0, 6'h01, 32'h0);
    check(o_ser_rdata, d);
    $display("fifo and serial test done");
    end_sim();
  end
  // Watchdog: the run needs under a thousand cycles, allow twenty thousand
  initial begin
    #(50 * 20000);
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
